/* core/evr_router.v */
// evr_router.v: event routing network with manual event injection
// assumes: all generators, users and the injecting master run on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "evr_consts.vh"

module evr_router #(
   parameter NUM_CH  = `EVR_NUM_CH,
   parameter NUM_SRC = `EVR_NUM_SRC,
   parameter SEL_W   = `EVR_SEL_W,
   parameter NUM_USR = 4
) (
   input  wire                     core_clk,
   input  wire                     nrst,
   input  wire [NUM_SRC-1:0]       src_stb,
   input  wire [NUM_SRC-1:0]       src_dat,
   input  wire [NUM_CH*SEL_W-1:0]  ch_sel,
   input  wire [NUM_CH-1:0]        man_dat,
   input  wire                     man_dat_we,
   input  wire [NUM_CH-1:0]        man_stb,
   input  wire                     man_stb_we,
   input  wire                     sleep_idle,
   input  wire [NUM_USR-1:0]       usr_data_mode,
   input  wire [NUM_USR*3-1:0]     usr_ch_sel,
   output reg  [NUM_CH-1:0]        ch_stb,
   output reg  [NUM_CH-1:0]        ch_dat,
   output reg  [NUM_USR-1:0]       usr_sig,
   output reg  [NUM_USR*2-1:0]     usr_code,
   output wire [NUM_CH-1:0]        man_dat_q
);

   // ------------------------------------------------------------
   // local sizes
   // ------------------------------------------------------------
   localparam CODE_W = 2;
   localparam UCH_W  = 3;

   // ------------------------------------------------------------
   // manual injection state
   // ------------------------------------------------------------
   // data register is held until rewritten; a strobe write fires once
   reg  [NUM_CH-1:0] man_dat_r;
   reg  [NUM_CH-1:0] man_fire_r;
   reg  [NUM_CH-1:0] man_val_r;
   reg  [NUM_CH-1:0] man_dval_r;
   reg  [NUM_CH-1:0] man_dat_nxt;
   reg  [NUM_CH-1:0] man_fire_nxt;
   reg  [NUM_CH-1:0] man_val_nxt;
   reg  [NUM_CH-1:0] man_dval_nxt;
   wire [NUM_CH-1:0] man_dat_eff;

   assign man_dat_q = man_dat_r;

   // strobe and data may be written in one cycle;
   // the new data is then used so the event matches what was written
   assign man_dat_eff = man_dat_we ? man_dat : man_dat_r;

   // data is captured with the strobe: a data write right after the
   // strobe must not change the event already in flight
   always @* begin
      man_dat_nxt  = man_dat_r;
      man_fire_nxt = {NUM_CH{1'b0}};
      man_val_nxt  = {NUM_CH{1'b0}};
      man_dval_nxt = {NUM_CH{1'b0}};
      if (man_dat_we) begin
         man_dat_nxt = man_dat;
      end
      // a channel is injected when its strobe or data bit is set
      if (man_stb_we) begin
         man_fire_nxt = man_stb | man_dat_eff;
         man_val_nxt  = man_stb;
         man_dval_nxt = man_dat_eff;
      end
   end

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         man_dat_r  <= {NUM_CH{1'b0}};
         man_fire_r <= {NUM_CH{1'b0}};
         man_val_r  <= {NUM_CH{1'b0}};
         man_dval_r <= {NUM_CH{1'b0}};
      end else begin
         man_dat_r  <= man_dat_nxt;
         man_fire_r <= man_fire_nxt;
         man_val_r  <= man_val_nxt;
         man_dval_r <= man_dval_nxt;
      end
   end

   // ------------------------------------------------------------
   // input register stage
   // ------------------------------------------------------------
   // sleep_idle is deliberately not used: the network is clocked in
   // both active and idle states, so routing never gates on it
   reg [NUM_SRC-1:0] src_stb_r;
   reg [NUM_SRC-1:0] src_dat_r;

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         src_stb_r <= {NUM_SRC{1'b0}};
         src_dat_r <= {NUM_SRC{1'b0}};
      end else begin
         src_stb_r <= src_stb;
         src_dat_r <= src_dat;
      end
   end

   // ------------------------------------------------------------
   // per-channel multiplexers and injection override
   // ------------------------------------------------------------
   wire [NUM_CH-1:0] mux_stb;
   wire [NUM_CH-1:0] mux_dat;
   wire [NUM_CH-1:0] ch_stb_nxt;
   wire [NUM_CH-1:0] ch_dat_nxt;

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
         wire [SEL_W-1:0] sel;
         wire             hit;
         assign sel = ch_sel[c*SEL_W +: SEL_W];
         // selector zero routes nothing but injection still passes
         assign hit = (sel != {SEL_W{1'b0}});
         assign mux_stb[c] = hit & src_stb_r[sel];
         assign mux_dat[c] = hit & src_dat_r[sel];
         // injected channels win for one cycle, the rest pass through
         assign ch_stb_nxt[c] = man_fire_r[c] ? man_val_r[c]  : mux_stb[c];
         assign ch_dat_nxt[c] = man_fire_r[c] ? man_dval_r[c] : mux_dat[c];
      end
   endgenerate

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ch_stb <= {NUM_CH{1'b0}};
         ch_dat <= {NUM_CH{1'b0}};
      end else begin
         ch_stb <= ch_stb_nxt;
         ch_dat <= ch_dat_nxt;
      end
   end

   // ------------------------------------------------------------
   // user-side decode
   // ------------------------------------------------------------
   // the strobe alone is the signaling event; code is the data event
   wire [NUM_USR-1:0]        usr_sig_nxt;
   wire [NUM_USR*CODE_W-1:0] usr_code_nxt;

   genvar u;
   generate
      for (u = 0; u < NUM_USR; u = u + 1) begin : g_usr
         wire [UCH_W-1:0]  uc;
         wire [CODE_W-1:0] code;
         wire [CODE_W-1:0] reduced;
         assign uc   = usr_ch_sel[u*UCH_W +: UCH_W];
         assign code = {ch_stb[uc], ch_dat[uc]};
         // signaling users ignore the data bit entirely
         assign reduced = code[`EVR_EV_STB_BIT] ? `EVR_EV_DATA02 : `EVR_EV_NONE;
         assign usr_sig_nxt[u] = code[`EVR_EV_STB_BIT];
         assign usr_code_nxt[u*CODE_W +: CODE_W] = usr_data_mode[u] ? code : reduced;
      end
   endgenerate

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         usr_sig  <= {NUM_USR{`EVR_MODE_RST}};
         usr_code <= {NUM_USR{`EVR_EV_NONE}};
      end else begin
         usr_sig  <= usr_sig_nxt;
         usr_code <= usr_code_nxt;
      end
   end

endmodule // evr_router
`default_nettype wire

/* shared/evr_consts.vh */
// evr_consts.vh: constants for the event routing block
// assumes: included by bare name from core design files
`ifndef EVR_CONSTS_VH
`define EVR_CONSTS_VH

// ------------------------------------------------------------
// network shape
// ------------------------------------------------------------
`define EVR_NUM_CH        8
`define EVR_NUM_SRC       16
`define EVR_SEL_W         4
`define EVR_SEL_NONE      4'h0

// ------------------------------------------------------------
// event encoding: bit 1 is the strobe, bit 0 is the data
// ------------------------------------------------------------
`define EVR_EV_STB_BIT    1
`define EVR_EV_DAT_BIT    0
`define EVR_EV_NONE       2'h0
`define EVR_EV_DATA01     2'h1
`define EVR_EV_DATA02     2'h2
`define EVR_EV_DATA03     2'h3

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define EVR_SEL_RST       4'h0
`define EVR_MODE_RST      1'h0
`define EVR_LAT_CYCLES    2

`endif

/* tb/evr_gen_model.sv */
// generator model: one-cycle source events on request
// assumes: driven by the bench on core_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module evr_gen_model (
   input wire            core_clk,
   input wire            fire,
   input wire [3:0]      idx,
   input wire [1:0]      code,
   output var reg [15:0] src_stb = 16'h0,
   output var reg [15:0] src_dat = 16'h0
);
   // lines drop back to zero: events last one cycle only
   always @(posedge core_clk) begin
      src_stb <= fire ? {15'h0, code[1]} << idx : 16'h0;
      src_dat <= fire ? {15'h0, code[0]} << idx : 16'h0;
   end
endmodule // evr_gen_model
`default_nettype wire

/* tb/evr_router_assertions.sv */
// checker: timing and decode relations at the router ports
// assumes: default router sizes, one clock
`timescale 1ns/1ps
`default_nettype none
module evr_chk (
   input wire        core_clk, nrst, man_dat_we, man_stb_we,
   input wire [15:0] src_stb, src_dat,
   input wire [31:0] ch_sel,
   input wire [11:0] usr_ch_sel,
   input wire [7:0]  man_dat, man_stb, ch_stb, ch_dat, usr_code, man_dat_q,
   input wire [3:0]  usr_data_mode, usr_sig
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_inject_strobe: assert property ((man_stb_we && man_stb != 8'h0) |->
      ##[1:3] (ch_stb & man_stb) == man_stb) else $error("strobe not injected");
   a_data_held: assert property (man_dat_we |=> man_dat_q == $past(man_dat))
      else $error("data register not loaded");
   a_quiet_chan: assert property ((ch_sel == 32'h0 && !man_stb_we)[*4] |->
      ch_stb == 8'h0 && ch_dat == 8'h0) else $error("event with nothing routed");
   a_src_route: assert property ((ch_sel[3:0] == 4'h1 && src_stb[1]) |->
      ##[1:3] ch_stb[0]) else $error("source strobe not routed");
   a_dat_route: assert property ((ch_sel[31:28] == 4'h2 && src_dat[2]) |->
      ##[1:3] ch_dat[7]) else $error("source data not routed");
   a_user_sig: assert property (usr_sig[0] == $past(ch_stb[usr_ch_sel[2:0]]))
      else $error("signaling user mismatch");
   a_user_code: assert property (usr_code[3:2] == ($past(usr_data_mode[1]) ?
      $past({ch_stb[usr_ch_sel[5:3]], ch_dat[usr_ch_sel[5:3]]}) :
      {$past(ch_stb[usr_ch_sel[5:3]]), 1'b0})) else $error("data user mismatch");
   a_user_reduce: assert property (!$past(usr_data_mode[2]) |->
      usr_code[4] == 1'b0 && usr_sig[2] == $past(ch_stb[usr_ch_sel[8:6]]))
      else $error("reduced decode mismatch");
endmodule // evr_chk
bind evr_router evr_chk i_chk (.core_clk(core_clk), .nrst(nrst), .man_dat_we(man_dat_we),
   .man_stb_we(man_stb_we), .src_stb(src_stb), .src_dat(src_dat), .ch_sel(ch_sel),
   .usr_ch_sel(usr_ch_sel), .man_dat(man_dat), .man_stb(man_stb), .ch_stb(ch_stb),
   .ch_dat(ch_dat), .usr_code(usr_code), .man_dat_q(man_dat_q),
   .usr_data_mode(usr_data_mode), .usr_sig(usr_sig));
`default_nettype wire

/* tb/tb.sv */
// testbench: manual injection and routed source events, queue scoreboard
// assumes: router and generator model on one 50 ns clock
`timescale 1ns/1ps
`default_nettype none
module tb;
   reg          core_clk, nrst, man_dat_we, man_stb_we, sleep_idle, fire;
   reg  [31:0]  ch_sel, sel;
   reg  [11:0]  usr_ch_sel;
   reg  [7:0]   man_dat, man_stb, m, es, ed;
   reg  [3:0]   usr_data_mode, k;
   reg  [1:0]   c, d;
   wire [15:0]  src_stb, src_dat;
   wire [7:0]   ch_stb, ch_dat, usr_code, man_dat_q;
   wire [3:0]   usr_sig;
   logic [15:0] q[$];
   integer      seed, i, j, err_total = 0, n_tests = 0;
   evr_gen_model i_gen (.core_clk(core_clk), .fire(fire), .idx(k), .code(d),
      .src_stb(src_stb), .src_dat(src_dat));
   evr_router i_dut (.core_clk(core_clk), .nrst(nrst), .src_stb(src_stb), .src_dat(src_dat),
      .ch_sel(ch_sel), .man_dat(man_dat), .man_dat_we(man_dat_we), .man_stb(man_stb),
      .man_stb_we(man_stb_we), .sleep_idle(sleep_idle), .usr_data_mode(usr_data_mode),
      .usr_ch_sel(usr_ch_sel), .ch_stb(ch_stb), .ch_dat(ch_dat), .usr_sig(usr_sig),
      .usr_code(usr_code), .man_dat_q(man_dat_q));
   task check(input [15:0] got, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d errors %0d", n_tests, err_total);
         if (err_total == 0 && n_tests > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // an event with no note pending is compared against zero and fails
   always @(posedge core_clk)
      if (nrst && (ch_stb | ch_dat) !== 8'h0)
         check({ch_stb, ch_dat}, q.size() ? q.pop_front() : 16'h0);
   initial begin
      seed = 32'h6086;
      {nrst, man_dat_we, man_stb_we, sleep_idle, fire} = 5'h0;
      {ch_sel, usr_ch_sel, man_dat, man_stb, usr_data_mode, k, d} = 70'h0;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      for (i = 0; i < 56; i = i + 1) begin
         @(posedge core_clk);
         m = $random(seed);
         c = i;
         usr_data_mode <= $random(seed);
         usr_ch_sel <= $random(seed);
         sleep_idle <= $random(seed);
         if (i < 16) begin
            ch_sel <= 32'h0;
            man_dat <= c[0] ? m : 8'h0;
            man_dat_we <= 1'b1;
            @(posedge core_clk);
            man_dat_we <= 1'b0; // data first, strobe next
            man_stb <= c[1] ? m : 8'h0;
            man_stb_we <= 1'b1;
            if (c != 2'h0 && m != 8'h0) q.push_back({c[1] ? m : 8'h0, c[0] ? m : 8'h0});
            @(posedge core_clk);
            man_stb_we <= 1'b0;
            repeat (5) @(posedge core_clk);
            check({8'h0, man_dat_q}, {8'h0, c[0] ? m : 8'h0});
         end else begin
            sel = $random(seed);
            k = (i < 18) ? i - 15 : $random(seed);
            if (i < 18) sel = {4'h2, sel[27:4], 4'h1};
            d = $random(seed);
            ch_sel <= sel;
            @(posedge core_clk);
            fire <= 1'b1;
            for (j = 0; j < 8; j = j + 1) begin
               es[j] = (k != 4'h0 && sel[j*4 +: 4] == k) & d[1];
               ed[j] = (k != 4'h0 && sel[j*4 +: 4] == k) & d[0];
            end
            if ({es, ed} != 16'h0) q.push_back({es, ed});
            @(posedge core_clk);
            fire <= 1'b0;
            repeat (5) @(posedge core_clk);
         end
      end
      for (i = 0; i < 20 && q.size() != 0; i = i + 1) @(posedge core_clk);
      if (q.size() != 0) err_total = err_total + 1;
      end_sim;
   end
endmodule // tb
`default_nettype wire
